//--- rtl/vtx_pkg.sv
// Constants for the TV timing, font warp, interlace and pixel mask block
package vtx_pkg;
    // ----------------------------------------
    // I/O ports
    // ----------------------------------------
    localparam logic [15:0] IO_CRTC_IDX_MONO  = 16'h03b4;
    localparam logic [15:0] IO_CRTC_DAT_MONO  = 16'h03b5;
    localparam logic [15:0] IO_CRTC_IDX_COLOR = 16'h03d4;
    localparam logic [15:0] IO_CRTC_DAT_COLOR = 16'h03d5;
    localparam logic [15:0] IO_PIXEL_MASK     = 16'h03c6;
    // ----------------------------------------
    // Register indices
    // ----------------------------------------
    localparam logic [7:0] IDX_REPAINT3  = 8'h1c;
    localparam logic [7:0] IDX_HALF_FLD  = 8'h39;
    localparam logic [7:0] IDX_TV_CTRL   = 8'h40;
    localparam logic [7:0] IDX_HACT_LOW  = 8'h41;
    localparam logic [7:0] IDX_HACT_HIGH = 8'h42;
    localparam logic [7:0] IDX_HSE_LOW   = 8'h43;
    localparam logic [7:0] IDX_HSE_HIGH  = 8'h44;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] RST_ZERO     = 8'h00;
    localparam logic [7:0] RST_HALF_FLD = 8'hff;
    localparam logic [7:0] RST_TV_CTRL  = 8'hff;
    localparam logic [7:0] RST_MASK     = 8'hff;
    localparam logic [7:0] HALF_FLD_OFF = 8'hff;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int BIT_SWAP_CL    = 7;
    localparam int BIT_TV_FORMAT  = 3;
    localparam int BIT_HS_OE      = 3;
    localparam int BIT_TEST_LUMA  = 6;
    localparam int BIT_FONT_WARP  = 7;
    localparam int HI_MSB         = 2;
    localparam int FIELD_W        = 11;
    // ----------------------------------------
    // Font plane layout
    // ----------------------------------------
    localparam int WARP_LINE_SHIFT = 11;
    localparam int WARP_SET_SHIFT  = 8;
    localparam int STD_SET_SHIFT   = 13;
    localparam int STD_CHAR_SHIFT  = 5;
endpackage

//--- rtl/vtx_tv_ext.sv
// TV timing, font warp, interlace enable and pixel mask logic
`timescale 1ns/1ps
module vtx_tv_ext #(
    parameter int LINE_PIXELS = 858
) (
    // Clock and reset
    input  wire logic        CORE_CLK_IN,
    input  wire logic        RESET_IN,
    // Host I/O port
    input  wire logic        IO_WR_IN,
    input  wire logic        IO_RD_IN,
    input  wire logic [15:0] IO_ADDR_IN,
    input  wire logic [7:0]  IO_WDATA_IN,
    output logic      [7:0]  IO_RDATA_OUT,
    // Video sources
    input  wire logic [7:0]  RED_IN,
    input  wire logic [7:0]  GREEN_IN,
    input  wire logic [7:0]  BLUE_IN,
    input  wire logic [7:0]  COMPOSITE_IN,
    input  wire logic [7:0]  CHROMA_IN,
    input  wire logic [7:0]  LUMA_IN,
    input  wire logic [7:0]  PROG_LUMA_IN,
    // Video input port hsync
    input  wire logic        VIP_HSYNC_OE_IN,
    input  wire logic        VIP_HSYNC_IN,
    // DAC outputs and TV pixel bus
    output logic      [7:0]  DAC_OUT_ONE_OUT,
    output logic      [7:0]  DAC_OUT_TWO_OUT,
    output logic      [7:0]  DAC_OUT_THREE_OUT,
    output logic      [7:0]  DAC_OUT_COMPOSITE_OUT,
    output logic      [7:0]  TV_PIXEL_BUS_OUT,
    output logic             TV_ACTIVE_OUT,
    // TV hsync pin
    output logic             TV_HSYNC_PIN_OUT,
    output logic             TV_HSYNC_PIN_OE_OUT,
    // Interlace
    output logic             INTERLACE_EN_OUT,
    // Font load
    input  wire logic        FONT_WR_IN,
    input  wire logic [2:0]  FONT_SET_IN,
    input  wire logic [7:0]  FONT_CHAR_IN,
    input  wire logic [4:0]  FONT_LINE_IN,
    input  wire logic [7:0]  FONT_DATA_IN,
    output logic             FONT_WE_OUT,
    output logic      [15:0] FONT_ADDR_OUT,
    output logic      [7:0]  FONT_DATA_OUT,
    // Palette
    input  wire logic        PIXEL_VALID_IN,
    input  wire logic [7:0]  PIXEL_IN,
    output logic             PALETTE_VALID_OUT,
    output logic      [7:0]  PALETTE_INDEX_OUT
);
    if (LINE_PIXELS < 2 || LINE_PIXELS > 2048)
        $error("LINE_PIXELS out of range");

    localparam logic [10:0] LAST_PIX = 11'(LINE_PIXELS - 1);

    function automatic logic [15:0] font_addr(input logic warp, input logic [2:0] set,
                                              input logic [7:0] chr, input logic [4:0] line);
        if (warp)
            font_addr = 16'((32'(line) << vtx_pkg::WARP_LINE_SHIFT)
                          + (32'(set) << vtx_pkg::WARP_SET_SHIFT) + 32'(chr));
        else
            font_addr = 16'((32'(set) << vtx_pkg::STD_SET_SHIFT)
                          + (32'(chr) << vtx_pkg::STD_CHAR_SHIFT) + 32'(line));
    endfunction

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    logic [7:0] idx_q, idx_d, rp3_q, rp3_d, hf_q, hf_d, ctl_q, ctl_d;
    logic [7:0] hal_q, hal_d, hah_q, hah_d, hsl_q, hsl_d, hsh_q, hsh_d;
    logic [7:0] mask_q, mask_d, rdata_q, rdata_d;
    logic       sel_idx, sel_dat, sel_mask;

    always_comb
    begin
        sel_idx  = IO_ADDR_IN == vtx_pkg::IO_CRTC_IDX_MONO || IO_ADDR_IN == vtx_pkg::IO_CRTC_IDX_COLOR;
        sel_dat  = IO_ADDR_IN == vtx_pkg::IO_CRTC_DAT_MONO || IO_ADDR_IN == vtx_pkg::IO_CRTC_DAT_COLOR;
        sel_mask = IO_ADDR_IN == vtx_pkg::IO_PIXEL_MASK;
        idx_d = idx_q;
        rp3_d = rp3_q;
        hf_d  = hf_q;
        ctl_d = ctl_q;
        hal_d = hal_q;
        hah_d = hah_q;
        hsl_d = hsl_q;
        hsh_d = hsh_q;
        mask_d = mask_q;
        rdata_d = rdata_q;
        if (IO_WR_IN && sel_idx)
            idx_d = IO_WDATA_IN;
        if (IO_WR_IN && sel_mask)
            mask_d = IO_WDATA_IN;
        if (IO_WR_IN && sel_dat)
        begin
            case (idx_q)
                vtx_pkg::IDX_REPAINT3:  rp3_d = IO_WDATA_IN;
                vtx_pkg::IDX_HALF_FLD:  hf_d  = IO_WDATA_IN;
                vtx_pkg::IDX_TV_CTRL:   ctl_d = IO_WDATA_IN;
                vtx_pkg::IDX_HACT_LOW:  hal_d = IO_WDATA_IN;
                vtx_pkg::IDX_HACT_HIGH: hah_d = IO_WDATA_IN;
                vtx_pkg::IDX_HSE_LOW:   hsl_d = IO_WDATA_IN;
                vtx_pkg::IDX_HSE_HIGH:  hsh_d = IO_WDATA_IN;
                default: ;
            endcase
        end
        if (IO_RD_IN)
        begin
            rdata_d = vtx_pkg::RST_ZERO;
            if (sel_idx)
                rdata_d = idx_q;
            else if (sel_mask)
                rdata_d = mask_q;
            else if (sel_dat)
            begin
                case (idx_q)
                    vtx_pkg::IDX_REPAINT3:  rdata_d = rp3_q;
                    vtx_pkg::IDX_HALF_FLD:  rdata_d = hf_q;
                    vtx_pkg::IDX_TV_CTRL:   rdata_d = ctl_q;
                    vtx_pkg::IDX_HACT_LOW:  rdata_d = hal_q;
                    vtx_pkg::IDX_HACT_HIGH: rdata_d = hah_q;
                    vtx_pkg::IDX_HSE_LOW:   rdata_d = hsl_q;
                    vtx_pkg::IDX_HSE_HIGH:  rdata_d = hsh_q;
                    default:                rdata_d = vtx_pkg::RST_ZERO;
                endcase
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (RESET_IN)
        begin
            idx_q   <= vtx_pkg::RST_ZERO;
            rp3_q   <= vtx_pkg::RST_ZERO;
            hf_q    <= vtx_pkg::RST_HALF_FLD;
            ctl_q   <= vtx_pkg::RST_TV_CTRL;
            hal_q   <= vtx_pkg::RST_ZERO;
            hah_q   <= vtx_pkg::RST_ZERO;
            hsl_q   <= vtx_pkg::RST_ZERO;
            hsh_q   <= vtx_pkg::RST_ZERO;
            mask_q  <= vtx_pkg::RST_MASK;
            rdata_q <= vtx_pkg::RST_ZERO;
        end
        else
        begin
            idx_q   <= idx_d;
            rp3_q   <= rp3_d;
            hf_q    <= hf_d;
            ctl_q   <= ctl_d;
            hal_q   <= hal_d;
            hah_q   <= hah_d;
            hsl_q   <= hsl_d;
            hsh_q   <= hsh_d;
            mask_q  <= mask_d;
            rdata_q <= rdata_d;
        end
    end

    // ----------------------------------------
    // TV line timing and pixel stream
    // ----------------------------------------
    logic [10:0] hcnt_q, hcnt_d, hact_q, hact_d, hse_q, hse_d;
    logic        phase_q, phase_d, hs_q, hs_d, act_q, act_d;
    logic [7:0]  bus_q, bus_d;
    logic        line_end;

    always_comb
    begin
        line_end = hcnt_q == LAST_PIX;
        hcnt_d   = line_end ? '0 : hcnt_q + 11'd1;
        phase_d  = line_end ? 1'b0 : ~phase_q;
        hact_d   = line_end ? {hah_q[vtx_pkg::HI_MSB:0], hal_q} : hact_q;
        hse_d    = line_end ? {hsh_q[vtx_pkg::HI_MSB:0], hsl_q} : hse_q;
        // Compare against the field in force for the pixel being entered
        hs_d     = hcnt_d < hse_d;
        act_d    = hcnt_d >= hact_d;
        if (hsh_q[vtx_pkg::BIT_TEST_LUMA])
            bus_d = PROG_LUMA_IN;
        else
            bus_d = (phase_q ^ hah_q[vtx_pkg::BIT_SWAP_CL]) ? LUMA_IN : CHROMA_IN;
    end

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (RESET_IN)
        begin
            hcnt_q  <= '0;
            hact_q  <= '0;
            hse_q   <= '0;
            phase_q <= 1'b0;
            hs_q    <= 1'b0;
            act_q   <= 1'b0;
            bus_q   <= '0;
        end
        else
        begin
            hcnt_q  <= hcnt_d;
            hact_q  <= hact_d;
            hse_q   <= hse_d;
            phase_q <= phase_d;
            hs_q    <= hs_d;
            act_q   <= act_d;
            bus_q   <= bus_d;
        end
    end

    // ----------------------------------------
    // Output stage
    // ----------------------------------------
    logic [7:0]  d1_d, d2_d, d3_d, dc_d, pal_d, fdat_d;
    logic        pin_d, pin_oe_d, il_d, fwe_d, pv_d;
    logic [15:0] fadr_d;

    always_comb
    begin
        if (hah_q[vtx_pkg::BIT_TV_FORMAT])
        begin
            d1_d = CHROMA_IN;
            d2_d = LUMA_IN;
            d3_d = COMPOSITE_IN;
        end
        else
        begin
            d1_d = RED_IN;
            d2_d = GREEN_IN;
            d3_d = BLUE_IN;
        end
        dc_d     = COMPOSITE_IN;
        pin_d    = ctl_q[vtx_pkg::BIT_HS_OE] ? hs_d : VIP_HSYNC_IN;
        pin_oe_d = ctl_q[vtx_pkg::BIT_HS_OE] | VIP_HSYNC_OE_IN;
        il_d     = hf_q != vtx_pkg::HALF_FLD_OFF;
        fwe_d    = FONT_WR_IN;
        fadr_d   = font_addr(rp3_q[vtx_pkg::BIT_FONT_WARP], FONT_SET_IN, FONT_CHAR_IN, FONT_LINE_IN);
        fdat_d   = FONT_DATA_IN;
        pv_d     = PIXEL_VALID_IN;
        pal_d    = PIXEL_IN & mask_q;
    end

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (RESET_IN)
        begin
            DAC_OUT_ONE_OUT       <= '0;
            DAC_OUT_TWO_OUT       <= '0;
            DAC_OUT_THREE_OUT     <= '0;
            DAC_OUT_COMPOSITE_OUT <= '0;
            TV_HSYNC_PIN_OUT      <= 1'b0;
            TV_HSYNC_PIN_OE_OUT   <= 1'b0;
            INTERLACE_EN_OUT      <= 1'b0;
            FONT_WE_OUT           <= 1'b0;
            FONT_ADDR_OUT         <= '0;
            FONT_DATA_OUT         <= '0;
            PALETTE_VALID_OUT     <= 1'b0;
            PALETTE_INDEX_OUT     <= '0;
        end
        else
        begin
            DAC_OUT_ONE_OUT       <= d1_d;
            DAC_OUT_TWO_OUT       <= d2_d;
            DAC_OUT_THREE_OUT     <= d3_d;
            DAC_OUT_COMPOSITE_OUT <= dc_d;
            TV_HSYNC_PIN_OUT      <= pin_d;
            TV_HSYNC_PIN_OE_OUT   <= pin_oe_d;
            INTERLACE_EN_OUT      <= il_d;
            FONT_WE_OUT           <= fwe_d;
            FONT_ADDR_OUT         <= fadr_d;
            FONT_DATA_OUT         <= fdat_d;
            PALETTE_VALID_OUT     <= pv_d;
            PALETTE_INDEX_OUT     <= pal_d;
        end
    end

    assign IO_RDATA_OUT     = rdata_q;
    assign TV_PIXEL_BUS_OUT = bus_q;
    assign TV_ACTIVE_OUT    = act_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (RESET_IN);

    property p_mask;
        PIXEL_VALID_IN |=> PALETTE_VALID_OUT && PALETTE_INDEX_OUT == ($past(PIXEL_IN) & $past(mask_q));
    endproperty
    a_mask: assert property (p_mask) else $error("pixel mask not applied");
    property p_fmt;
        hah_q[vtx_pkg::BIT_TV_FORMAT] |=> DAC_OUT_ONE_OUT == $past(CHROMA_IN) && DAC_OUT_THREE_OUT == $past(COMPOSITE_IN);
    endproperty
    a_fmt: assert property (p_fmt) else $error("DAC format wrong");
    property p_hs_oe;
        !ctl_q[vtx_pkg::BIT_HS_OE] && !VIP_HSYNC_OE_IN |=> !TV_HSYNC_PIN_OE_OUT;
    endproperty
    a_hs_oe: assert property (p_hs_oe) else $error("hsync pin driven while disabled");
    property p_hs_src;
        ctl_q[vtx_pkg::BIT_HS_OE] |=> TV_HSYNC_PIN_OE_OUT && TV_HSYNC_PIN_OUT == hs_q;
    endproperty
    a_hs_src: assert property (p_hs_src) else $error("hsync pin not from TV generator");
    property p_il;
        ##1 INTERLACE_EN_OUT == ($past(hf_q) != vtx_pkg::HALF_FLD_OFF);
    endproperty
    a_il: assert property (p_il) else $error("interlace enable wrong");
    property p_warp;
        FONT_WR_IN && rp3_q[vtx_pkg::BIT_FONT_WARP] |=>
            FONT_ADDR_OUT == 16'({$past(FONT_LINE_IN), $past(FONT_SET_IN), $past(FONT_CHAR_IN)});
    endproperty
    a_warp: assert property (p_warp) else $error("warped font address wrong");
    property p_hs_width;
        line_end ##1 (hcnt_q == 11'd0) |-> hs_q == (hse_q != 11'd0);
    endproperty
    a_hs_width: assert property (p_hs_width) else $error("hsync width wrong at line start");
    property p_latch;
        line_end |=> hact_q == {$past(hah_q[vtx_pkg::HI_MSB:0]), $past(hal_q)};
    endproperty
    a_latch: assert property (p_latch) else $error("active start not latched at line end");
    property p_test;
        hsh_q[vtx_pkg::BIT_TEST_LUMA] |=> TV_PIXEL_BUS_OUT == $past(PROG_LUMA_IN);
    endproperty
    a_test: assert property (p_test) else $error("test luma route wrong");
    property p_swap;
        !hsh_q[vtx_pkg::BIT_TEST_LUMA] && !(phase_q ^ hah_q[vtx_pkg::BIT_SWAP_CL]) |=>
            TV_PIXEL_BUS_OUT == $past(CHROMA_IN);
    endproperty
    a_swap: assert property (p_swap) else $error("chroma luma order wrong");
endmodule

//--- test/tb.sv
// Self-checking bench for the TV timing, font warp, interlace and pixel mask block
`timescale 1ns/1ps
module tb;
    localparam int         LP        = 300;
    localparam logic [7:0] H_TOTAL   = 8'h5f;
    localparam logic [7:0] H_RETRACE = 8'h50;
    logic        clk, rst, wr, rd, fwr, vld, voe, vhs;
    logic        act, hso, hsoe, ilace, fwe, pv, lvl;
    logic [15:0] addr, faddr;
    logic [7:0]  wd, rdata, r, g, b, cv, ch, lu, pl, pix, fch, fdat, v;
    logic [7:0]  d1, d2, d3, dc, bus, pidx, fdo;
    logic [2:0]  fset;
    logic [4:0]  fline;
    logic [10:0] width;
    int          failures, samples_checked, n;

    vtx_tv_ext #(.LINE_PIXELS(LP)) u_dut (
        .CORE_CLK_IN(clk), .RESET_IN(rst), .IO_WR_IN(wr), .IO_RD_IN(rd), .IO_ADDR_IN(addr),
        .IO_WDATA_IN(wd), .IO_RDATA_OUT(rdata), .RED_IN(r), .GREEN_IN(g), .BLUE_IN(b),
        .COMPOSITE_IN(cv), .CHROMA_IN(ch), .LUMA_IN(lu), .PROG_LUMA_IN(pl),
        .VIP_HSYNC_OE_IN(voe), .VIP_HSYNC_IN(vhs), .DAC_OUT_ONE_OUT(d1), .DAC_OUT_TWO_OUT(d2),
        .DAC_OUT_THREE_OUT(d3), .DAC_OUT_COMPOSITE_OUT(dc), .TV_PIXEL_BUS_OUT(bus),
        .TV_ACTIVE_OUT(act), .TV_HSYNC_PIN_OUT(hso), .TV_HSYNC_PIN_OE_OUT(hsoe),
        .INTERLACE_EN_OUT(ilace), .FONT_WR_IN(fwr), .FONT_SET_IN(fset), .FONT_CHAR_IN(fch),
        .FONT_LINE_IN(fline), .FONT_DATA_IN(fdat), .FONT_WE_OUT(fwe), .FONT_ADDR_OUT(faddr),
        .FONT_DATA_OUT(fdo), .PIXEL_VALID_IN(vld), .PIXEL_IN(pix), .PALETTE_VALID_OUT(pv),
        .PALETTE_INDEX_OUT(pidx));

    vtx_tv_encoder_model u_enc (.clk_in(clk), .rst_in(rst), .pin_in(hso), .pin_oe_in(hsoe),
        .line_level_out(lvl), .width_out(width));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        samples_checked++;
        if (s !== e)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        wr   <= 1'b1;
        addr <= a;
        wd   <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic io_rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic crw(input logic [7:0] i, input logic [7:0] d);
        io_wr(vtx_pkg::IO_CRTC_IDX_COLOR, i);
        io_wr(vtx_pkg::IO_CRTC_DAT_COLOR, d);
    endtask
    task automatic crr(input logic [7:0] i, output logic [7:0] d);
        io_wr(vtx_pkg::IO_CRTC_IDX_MONO, i);
        io_rd(vtx_pkg::IO_CRTC_DAT_MONO, d);
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wait_rise;
        int k;
        k = 0;
        while (hso !== 1'b0 && k < 2 * LP) @(posedge clk) #1 k++;
        while (hso !== 1'b1 && k < 4 * LP) @(posedge clk) #1 k++;
        chk("hsync rise", 16'h0001, {15'h0000, hso});
    endtask
    task automatic font(input logic [2:0] s, input logic [7:0] c, input logic [4:0] l);
        @(posedge clk);
        fwr   <= 1'b1;
        fset  <= s;
        fch   <= c;
        fline <= l;
        fdat  <= c ^ 8'h3c;
        @(posedge clk);
        fwr <= 1'b0;
        #1;
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ----------------------------------------
    // Clock, watchdog and tests
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial
    begin
        #(30000 * 100);
        failures++;
        $display("mismatch watchdog expected done seen timeout");
        final_report;
    end
    initial
    begin
        rst = 1'b1; wr = 1'b0; rd = 1'b0; fwr = 1'b0; vld = 1'b1; voe = 1'b0; vhs = 1'b0;
        addr = 16'h0000; wd = 8'h00; fset = 3'h0; fch = 8'h00; fline = 5'h00; fdat = 8'h00;
        r = 8'h10; g = 8'h20; b = 8'h30; cv = 8'h40; ch = 8'h11; lu = 8'h22; pl = 8'h5a; pix = 8'ha5;
        failures = 0;
        samples_checked = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        cyc(2);
        chk("pin oe reset", 16'h0001, {15'h0000, hsoe});
        chk("interlace reset", 16'h0000, {15'h0000, ilace});
        io_rd(vtx_pkg::IO_PIXEL_MASK, v);
        chk("mask reset", 16'h00ff, {8'h00, v});
        crr(vtx_pkg::IDX_HALF_FLD, v);
        chk("half field reset", 16'h00ff, {8'h00, v});
        for (int i = 8'h42; i <= 8'h44; i++)
        begin
            crr(8'(i), v);
            chk("timing reg reset", 16'h0000, {8'h00, v});
        end
        chk("index unmasked", 16'h00a5, {8'h00, pidx});
        io_wr(vtx_pkg::IO_PIXEL_MASK, 8'h0f);
        cyc(3);
        chk("index masked", 16'h0005, {8'h00, pidx});
        chk("palette valid", 16'h0001, {15'h0000, pv});
        crw(8'h7f, 8'h55);
        crr(8'h7f, v);
        chk("unmapped index", 16'h0000, {8'h00, v});
        $display("test reset_mask done");
        crw(vtx_pkg::IDX_HACT_HIGH, 8'h08);
        cyc(3);
        chk("dac one", {8'h00, ch}, {8'h00, d1});
        chk("dac two", {8'h00, lu}, {8'h00, d2});
        chk("dac three", {8'h00, cv}, {8'h00, d3});
        chk("dac comp", {8'h00, cv}, {8'h00, dc});
        crw(vtx_pkg::IDX_HACT_HIGH, 8'h00);
        cyc(3);
        chk("dac one rgb", {8'h00, r}, {8'h00, d1});
        chk("dac two rgb", {8'h00, g}, {8'h00, d2});
        chk("dac three rgb", {8'h00, b}, {8'h00, d3});
        chk("dac comp rgb", {8'h00, cv}, {8'h00, dc});
        $display("test output_format done");
        // Sync-end bit 7 kept equal to retrace start bit 0, chosen zero
        crw(vtx_pkg::IDX_HSE_LOW, 8'h02);
        crw(vtx_pkg::IDX_HSE_HIGH, 8'h01);
        crw(vtx_pkg::IDX_HACT_LOW, 8'h03);
        crw(vtx_pkg::IDX_HACT_HIGH, 8'h01);
        wait_rise;
        wait_rise;
        n = 0;
        while (act !== 1'b1 && n < LP) @(posedge clk) #1 n++;
        chk("active start", 16'd259, 16'(n));
        n = 0;
        while (hso !== 1'b0 && n < LP) @(posedge clk) #1 n++;
        cyc(1);
        chk("hsync width", 16'd258, {5'h00, width});
        wait_rise;
        // Bus shows pixel zero one cycle after the counter wraps
        cyc(1);
        chk("first byte", {8'h00, ch}, {8'h00, bus});
        crw(vtx_pkg::IDX_HACT_HIGH, 8'h81);
        wait_rise;
        wait_rise;
        cyc(1);
        chk("first byte swapped", {8'h00, lu}, {8'h00, bus});
        cyc(1);
        chk("second byte swapped", {8'h00, ch}, {8'h00, bus});
        crw(vtx_pkg::IDX_HACT_HIGH, 8'h01);
        crw(vtx_pkg::IDX_HSE_HIGH, 8'h41);
        wait_rise;
        cyc(2);
        chk("test luma bus", {8'h00, pl}, {8'h00, bus});
        crw(vtx_pkg::IDX_HSE_HIGH, 8'h01);
        $display("test tv_timing done");
        crw(vtx_pkg::IDX_TV_CTRL, 8'hf7);
        cyc(3);
        chk("pin oe off", 16'h0000, {15'h0000, hsoe});
        @(posedge clk);
        voe <= 1'b1;
        vhs <= 1'b1;
        cyc(3);
        chk("pin oe vip", 16'h0001, {15'h0000, hsoe});
        chk("pin level vip", 16'h0001, {15'h0000, lvl});
        @(posedge clk);
        voe <= 1'b0;
        crw(vtx_pkg::IDX_TV_CTRL, 8'hff);
        $display("test hsync_pin done");
        // Half-field start from odd horizontal total and retrace start
        // Vertical total odd, blank start odd, blank end even are set outside this block
        crw(vtx_pkg::IDX_HALF_FLD, H_RETRACE - (H_TOTAL + 8'h05) / 2);
        cyc(3);
        chk("interlace on", 16'h0001, {15'h0000, ilace});
        crw(vtx_pkg::IDX_HALF_FLD, 8'hff);
        cyc(3);
        chk("interlace off", 16'h0000, {15'h0000, ilace});
        $display("test interlace done");
        crw(vtx_pkg::IDX_REPAINT3, 8'h80);
        font(3'h3, 8'h41, 5'h02);
        chk("font we", 16'h0001, {15'h0000, fwe});
        chk("font addr", 16'(2 * 2048 + 3 * 256 + 'h41), faddr);
        chk("font data", 16'h007d, {8'h00, fdo});
        font(3'h7, 8'hff, 5'h00);
        chk("font addr top", 16'd2047, faddr);
        crw(vtx_pkg::IDX_REPAINT3, 8'h00);
        font(3'h1, 8'h02, 5'h03);
        chk("font std", 16'((1 << vtx_pkg::STD_SET_SHIFT) + (2 << vtx_pkg::STD_CHAR_SHIFT) + 3), faddr);
        $display("test font_warp done");
        final_report;
    end
endmodule

//--- test/vtx_tv_encoder_model.sv
// Behavioural TV encoder that watches the hsync pin and measures its pulse width
`timescale 1ns/1ps
module vtx_tv_encoder_model (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // Pin from the device
    input  wire logic        pin_in,
    input  wire logic        pin_oe_in,
    // Observations
    output logic             line_level_out,
    output logic      [10:0] width_out
);
    // ----------------------------------------
    // Line level and pulse width
    // ----------------------------------------
    logic [10:0] cnt_q;
    logic        last_q;
    // Undriven line shows the inverse of its last level
    assign line_level_out = pin_oe_in ? pin_in : ~last_q;
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            cnt_q     <= 11'h000;
            width_out <= 11'h000;
            last_q    <= 1'b0;
        end
        else
        begin
            if (pin_oe_in)
                last_q <= pin_in;
            if (line_level_out && pin_oe_in)
                cnt_q <= cnt_q + 11'h001;
            else if (cnt_q != 11'h000)
            begin
                width_out <= cnt_q;
                cnt_q     <= 11'h000;
            end
        end
    end
endmodule
